// ==== dv/rx_irq_mode_gpo_select_properties.sv ====
// checker for trigger-mode registers, the cs crc interrupt event and gp output one select
`timescale 1ns/1ps
`include "rx_irq_gpo_consts.vh"
module rx_irq_mode_gpo_select_props (
  input wire               i_core_clk,
  input wire               i_arst_n,
  input wire               i_reg_wr_en,
  input wire               i_reg_rd_en,
  input wire [`ADDR_W-1:0] i_reg_addr,
  input wire [`DATA_W-1:0] i_reg_wdata,
  input wire [`DATA_W-1:0] o_reg_rdata,
  input wire               o_reg_rd_valid,
  input wire               i_cs_crc_err,
  input wire               i_parity_err,
  input wire               i_tx_irq,
  input wire               o_cs_crc_irq_event,
  input wire               o_gp_out_pin_one
);
  reg [1:0] cs_mode_ff;
  reg [3:0] sel_ff;
  // shadow copies; a reserved code leaves the field as it was
  always @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cs_mode_ff <= 2'h0;
      sel_ff     <= 4'h0;
    end else if (i_reg_wr_en) begin
      if (i_reg_addr == `OFS_TRIG_MODE_B && i_reg_wdata[7:6] != `TRIG_RSVD) cs_mode_ff <= i_reg_wdata[7:6];
      if (i_reg_addr == `OFS_PIN_ONE_SEL && i_reg_wdata[3:0] != `SEL_RSVD) sel_ff <= i_reg_wdata[3:0];
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);
  rd_answer_a: assert property (i_reg_rd_en |=> o_reg_rd_valid) else $error("read not answered");
  mode_c_zero_a: assert property ((i_reg_rd_en && i_reg_addr == `OFS_TRIG_MODE_C) |=>
    o_reg_rdata[7:2] == 6'h00) else $error("mode c upper bits set");
  sel_readback_a: assert property ((i_reg_rd_en && i_reg_addr == `OFS_PIN_ONE_SEL) |=>
    o_reg_rdata == {4'h0, $past(sel_ff)}) else $error("select readback wrong");
  cs_mode_read_a: assert property ((i_reg_rd_en && i_reg_addr == `OFS_TRIG_MODE_B) |=>
    o_reg_rdata[7:6] == $past(cs_mode_ff)) else $error("crc mode readback wrong");
  cs_rise_a: assert property ((cs_mode_ff == `TRIG_RISE && i_cs_crc_err && !$past(i_cs_crc_err)) |=>
    o_cs_crc_irq_event) else $error("rising event missing");
  cs_fall_a: assert property ((cs_mode_ff == `TRIG_FALL && !i_cs_crc_err && $past(i_cs_crc_err)) |=>
    o_cs_crc_irq_event) else $error("falling event missing");
  cs_level_a: assert property (cs_mode_ff == `TRIG_LEVEL |=> o_cs_crc_irq_event == $past(i_cs_crc_err))
    else $error("level event wrong");
  pin_low_a: assert property (sel_ff == `SEL_LOW |=> !o_gp_out_pin_one) else $error("pin not low");
  pin_high_a: assert property (sel_ff == `SEL_HIGH |=> o_gp_out_pin_one) else $error("pin not high");
  pin_tx_irq_a: assert property (sel_ff == `SEL_TX_IRQ_N |=> o_gp_out_pin_one == !$past(i_tx_irq))
    else $error("pin not inverted tx irq");
  pin_parity_a: assert property (sel_ff == `SEL_PARITY_ERR |=> o_gp_out_pin_one == $past(i_parity_err))
    else $error("pin not parity error");
  cover property (o_cs_crc_irq_event);
  cover property (sel_ff == `SEL_TX_SYNC);
  cover property (o_reg_rd_valid);
endmodule
bind rx_irq_mode_gpo_select rx_irq_mode_gpo_select_props rx_irq_mode_gpo_select_props_inst (
  .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_reg_wr_en(i_reg_wr_en), .i_reg_rd_en(i_reg_rd_en),
  .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_reg_rd_valid(o_reg_rd_valid),
  .i_cs_crc_err(i_cs_crc_err), .i_parity_err(i_parity_err), .i_tx_irq(i_tx_irq),
  .o_cs_crc_irq_event(o_cs_crc_irq_event), .o_gp_out_pin_one(o_gp_out_pin_one));

// ==== dv/rx_irq_mode_gpo_select_tb_top.sv ====
// self-checking bench for the trigger-mode registers and gp output one select
`timescale 1ns/1ps
module rx_irq_mode_gpo_select_tb_top;
  reg         clk;
  reg         rst_n;
  reg         wr_en;
  reg         rd_en;
  reg  [7:0]  addr;
  reg  [7:0]  wdata;
  reg  [4:0]  err;
  reg  [15:0] src;
  reg  [15:0] sm;
  reg         c1;
  reg         c2;
  reg         e;
  wire [7:0]  rdata;
  wire        rd_valid;
  wire [4:0]  ev;
  wire        pin;
  integer     err_total;
  integer     samples_checked;
  integer     cyc;
  integer     k;
  integer     m;
  integer     s;
  integer     v;
  localparam [7:0] PAT = 8'h38;
  rx_irq_mode_gpo_select rx_irq_mode_gpo_select_inst (
    .i_core_clk(clk), .i_arst_n(rst_n), .i_reg_wr_en(wr_en), .i_reg_rd_en(rd_en), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rd_valid(rd_valid), .i_cs_crc_err(err[0]),
    .i_parity_err(err[1]), .i_validity_err(err[2]), .i_biphase_err(err[3]), .i_slip_err(err[4]),
    .o_cs_crc_irq_event(ev[0]), .o_parity_irq_event(ev[1]), .o_validity_irq_event(ev[2]),
    .o_biphase_irq_event(ev[3]), .o_slip_irq_event(ev[4]), .i_tx_irq(src[3]), .i_rx_irq(src[4]),
    .i_rx_emphasis(src[5]), .i_rx_non_audio(src[6]), .i_rx_non_valid(src[7]), .i_rx_cs_bit(src[8]),
    .i_rx_user_bit(src[9]), .i_rx_block_clk(src[10]), .i_rx_copy_bit(src[11]), .i_rx_gen_bit(src[12]),
    .i_rx_sync_clk(src[14]), .i_tx_sync_clk(src[15]),
    .o_gp_out_pin_one(pin));
  task check(input string what, input [7:0] seen, input [7:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk);
      wr_en <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
      wr_en <= 1'b0;
    end
  endtask
  // read data is judged half a cycle after the answering edge
  task rd(input [7:0] a, input [7:0] exp, input string what);
    begin
      @(posedge clk);
      rd_en <= 1'b1;
      addr  <= a;
      @(posedge clk);
      rd_en <= 1'b0;
      @(negedge clk);
      check(what, rdata, exp);
      check("read valid", {7'h00, rd_valid}, 8'h01);
    end
  endtask
  task t_reset_regs;
    begin
      rd(8'h19, 8'h00, "mode b reset");
      rd(8'h1A, 8'h00, "mode c reset");
      rd(8'h1B, 8'h00, "select reset");
      rd(8'h20, 8'h00, "unmapped read");
      check("pin reset", pin, 8'h00);
    end
  endtask
  // mode 0 runs on reset defaults, so it also proves the rising-edge default
  task t_events;
    begin
      for (m = 0; m < 3; m = m + 1) begin
        if (m != 0) begin
          wr(8'h19, {4{m[1:0]}});
          wr(8'h1A, {6'h00, m[1:0]});
        end
        for (k = 0; k < 8; k = k + 1) begin
          @(posedge clk);
          err <= {5{PAT[k]}};
          @(negedge clk);
          if (k >= 2) begin
            c1 = PAT[k-1];
            c2 = PAT[k-2];
            e = (m == 0) ? (c1 & ~c2) : (m == 1) ? (~c1 & c2) : c1;
            check("irq events", {3'h0, ev}, {3'h0, {5{e}}});
          end
        end
      end
    end
  endtask
  task t_fields;
    begin
      for (m = 0; m < 3; m = m + 1) begin
        wr(8'h19, {4{m[1:0]}});
        rd(8'h19, {4{m[1:0]}}, "mode b fields");
        wr(8'h1A, {6'h3F, m[1:0]});
        rd(8'h1A, {6'h00, m[1:0]}, "mode c field");
      end
      wr(8'h19, 8'h9C);
      rd(8'h19, 8'h98, "mode b reserved hold");
      wr(8'h1A, 8'h03);
      rd(8'h1A, 8'h02, "mode c reserved hold");
    end
  endtask
  // only the selected source takes the test level, the rest show its inverse
  task t_pin;
    begin
      for (s = 0; s < 16; s = s + 1) begin
        if (s != 2) begin
          wr(8'h1B, s[7:0]);
          for (v = 0; v < 2; v = v + 1) begin
            sm = v ? (16'h0001 << s) : ~(16'h0001 << s);
            @(posedge clk);
            src <= sm;
            err <= {3'h0, sm[13], 1'h0};
            @(posedge clk);
            @(negedge clk);
            e = (s == 0) ? 1'b0 : (s == 1) ? 1'b1 : (s >= 3 && s <= 5) ? ~v[0] : v[0];
            check("gp pin", {7'h00, pin}, {7'h00, e});
          end
        end
      end
      wr(8'h1B, 8'hF2);
      rd(8'h1B, 8'h0F, "select reserved hold");
      check("pin after reserved", {7'h00, pin}, 8'h01);
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total = err_total + 1;
      finish_test;
    end
  end
  initial begin
    rst_n = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    err = 5'h00;
    src = 16'h0000;
    err_total = 0;
    samples_checked = 0;
    cyc = 0;
    repeat (4) @(posedge clk);
    // released by a non-blocking change at an edge, so that edge still sees reset
    rst_n <= 1'b1;
    t_reset_regs;
    t_events;
    t_fields;
    t_pin;
    finish_test;
  end
endmodule

// ==== hw/gpo_source_mux.v ====
// selects the static level or receiver/transmitter signal that drives gp output pin one
`timescale 1ns/1ps
`include "rx_irq_gpo_consts.vh"

module gpo_source_mux (
  input  wire                 i_core_clk,
  input  wire                 i_arst_n,
  input  wire [`SEL_W-1:0]    i_sel,
  input  wire                 i_tx_irq,
  input  wire                 i_rx_irq,
  input  wire                 i_rx_emphasis,
  input  wire                 i_rx_non_audio,
  input  wire                 i_rx_non_valid,
  input  wire                 i_rx_cs_bit,
  input  wire                 i_rx_user_bit,
  input  wire                 i_rx_block_clk,
  input  wire                 i_rx_copy_bit,
  input  wire                 i_rx_gen_bit,
  input  wire                 i_rx_parity_err,
  input  wire                 i_rx_sync_clk,
  input  wire                 i_tx_sync_clk,
  output reg                  o_pin
);

  reg nxt_pin;

  always @* begin
    nxt_pin = o_pin;
    case (i_sel)
      `SEL_LOW:        nxt_pin = 1'b0;
      `SEL_HIGH:       nxt_pin = 1'b1;
      `SEL_TX_IRQ_N:   nxt_pin = ~i_tx_irq;
      `SEL_RX_IRQ_N:   nxt_pin = ~i_rx_irq;
      `SEL_EMPH_N:     nxt_pin = ~i_rx_emphasis;
      `SEL_NON_AUDIO:  nxt_pin = i_rx_non_audio;
      `SEL_NON_VALID:  nxt_pin = i_rx_non_valid;
      `SEL_CS_BIT:     nxt_pin = i_rx_cs_bit;
      `SEL_USER_BIT:   nxt_pin = i_rx_user_bit;
      `SEL_BLOCK_CLK:  nxt_pin = i_rx_block_clk;
      `SEL_COPY_BIT:   nxt_pin = i_rx_copy_bit;
      `SEL_GEN_BIT:    nxt_pin = i_rx_gen_bit;
      `SEL_PARITY_ERR: nxt_pin = i_rx_parity_err;
      `SEL_RX_SYNC:    nxt_pin = i_rx_sync_clk;
      `SEL_TX_SYNC:    nxt_pin = i_tx_sync_clk;
      default:         nxt_pin = o_pin;
    endcase
  end

  // registered pin costs one cycle of delay on the clock-like sources
  always @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pin <= 1'b0;
    end else begin
      o_pin <= nxt_pin;
    end
  end

endmodule

// ==== hw/irq_trigger_detect.v ====
// one receiver error source: turns a condition level into an interrupt event per trigger mode
`timescale 1ns/1ps
`include "rx_irq_gpo_consts.vh"

module irq_trigger_detect (
  input  wire                 i_core_clk,
  input  wire                 i_arst_n,
  input  wire                 i_cond,
  input  wire [`TRIG_W-1:0]   i_mode,
  output reg                  o_event
);

  reg cond_prev_ff;
  reg nxt_event;

  always @* begin
    case (i_mode)
      `TRIG_RISE:  nxt_event = i_cond & ~cond_prev_ff;
      `TRIG_FALL:  nxt_event = ~i_cond & cond_prev_ff;
      `TRIG_LEVEL: nxt_event = i_cond;
      // reserved code cannot be stored, but stay quiet if it ever appears
      default:     nxt_event = 1'b0;
    endcase
  end

  // prev starts low so a condition already high at release counts as a rising edge
  always @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cond_prev_ff <= 1'b0;
      o_event      <= 1'b0;
    end else begin
      cond_prev_ff <= i_cond;
      o_event      <= nxt_event;
    end
  end

endmodule

// ==== hw/rx_irq_gpo_consts.vh ====
// register map, field layout, codes and reset values of the receiver trigger-mode and pin one select block
`ifndef RX_IRQ_GPO_CONSTS_VH
`define RX_IRQ_GPO_CONSTS_VH

// host port geometry
`define ADDR_W               8
`define DATA_W               8

// register offsets
`define OFS_TRIG_MODE_B      8'h19
`define OFS_TRIG_MODE_C      8'h1A
`define OFS_PIN_ONE_SEL      8'h1B

// trigger-mode fields inside rx_irq_trigger_mode_b / _c
`define TRIG_W               2
`define CS_CRC_TRIG_MSB      7
`define CS_CRC_TRIG_LSB      6
`define PARITY_TRIG_MSB      5
`define PARITY_TRIG_LSB      4
`define VALIDITY_TRIG_MSB    3
`define VALIDITY_TRIG_LSB    2
`define BIPHASE_TRIG_MSB     1
`define BIPHASE_TRIG_LSB     0
`define SLIP_TRIG_MSB        1
`define SLIP_TRIG_LSB        0

// trigger-mode encodings
`define TRIG_RISE            2'h0
`define TRIG_FALL            2'h1
`define TRIG_LEVEL           2'h2
`define TRIG_RSVD            2'h3
`define TRIG_RESET           2'h0

// gp output one select field
`define SEL_W                4
`define SEL_MSB              3
`define SEL_LSB              0
`define SEL_RESET            4'h0
`define SEL_LOW              4'h0
`define SEL_HIGH             4'h1
`define SEL_RSVD             4'h2
`define SEL_TX_IRQ_N         4'h3
`define SEL_RX_IRQ_N         4'h4
`define SEL_EMPH_N           4'h5
`define SEL_NON_AUDIO        4'h6
`define SEL_NON_VALID        4'h7
`define SEL_CS_BIT           4'h8
`define SEL_USER_BIT         4'h9
`define SEL_BLOCK_CLK        4'hA
`define SEL_COPY_BIT         4'hB
`define SEL_GEN_BIT          4'hC
`define SEL_PARITY_ERR       4'hD
`define SEL_RX_SYNC          4'hE
`define SEL_TX_SYNC          4'hF

// number of receiver error sources with a trigger mode
`define NUM_ERR_SRC          5
`define ERR_CS_CRC           0
`define ERR_PARITY           1
`define ERR_VALIDITY         2
`define ERR_BIPHASE          3
`define ERR_SLIP             4

`endif

// ==== hw/rx_irq_mode_gpo_select.v ====
// receiver error trigger-mode registers and gp output one source select behind the host register port
`timescale 1ns/1ps
`include "rx_irq_gpo_consts.vh"

module rx_irq_mode_gpo_select (
  input  wire                 i_core_clk,
  input  wire                 i_arst_n,
  // host register port, already decoded from the serial host interface
  input  wire                 i_reg_wr_en,
  input  wire                 i_reg_rd_en,
  input  wire [`ADDR_W-1:0]   i_reg_addr,
  input  wire [`DATA_W-1:0]   i_reg_wdata,
  output reg  [`DATA_W-1:0]   o_reg_rdata,
  output reg                  o_reg_rd_valid,
  // receiver error conditions, active high levels
  input  wire                 i_cs_crc_err,
  input  wire                 i_parity_err,
  input  wire                 i_validity_err,
  input  wire                 i_biphase_err,
  input  wire                 i_slip_err,
  // interrupt events toward the status/mask logic
  output wire                 o_cs_crc_irq_event,
  output wire                 o_parity_irq_event,
  output wire                 o_validity_irq_event,
  output wire                 o_biphase_irq_event,
  output wire                 o_slip_irq_event,
  // sources for the gp output pin
  input  wire                 i_tx_irq,
  input  wire                 i_rx_irq,
  input  wire                 i_rx_emphasis,
  input  wire                 i_rx_non_audio,
  input  wire                 i_rx_non_valid,
  input  wire                 i_rx_cs_bit,
  input  wire                 i_rx_user_bit,
  input  wire                 i_rx_block_clk,
  input  wire                 i_rx_copy_bit,
  input  wire                 i_rx_gen_bit,
  input  wire                 i_rx_sync_clk,
  input  wire                 i_tx_sync_clk,
  output wire                 o_gp_out_pin_one
);

  reg  [`TRIG_W-1:0]              cs_crc_irq_trigger_ff;
  reg  [`TRIG_W-1:0]              parity_irq_trigger_ff;
  reg  [`TRIG_W-1:0]              validity_irq_trigger_ff;
  reg  [`TRIG_W-1:0]              biphase_irq_trigger_ff;
  reg  [`TRIG_W-1:0]              slip_irq_trigger_ff;
  reg  [`SEL_W-1:0]               gp_out_one_source_ff;
  reg  [`DATA_W-1:0]              nxt_rdata;
  wire                            wr_mode_b;
  wire                            wr_mode_c;
  wire                            wr_pin_one;
  wire [`TRIG_W-1:0]              wr_cs_crc;
  wire [`TRIG_W-1:0]              wr_parity;
  wire [`TRIG_W-1:0]              wr_validity;
  wire [`TRIG_W-1:0]              wr_biphase;
  wire [`TRIG_W-1:0]              wr_slip;
  wire [`SEL_W-1:0]               wr_source;
  wire [`NUM_ERR_SRC-1:0]         err_cond;
  wire [`NUM_ERR_SRC*`TRIG_W-1:0] err_mode;
  wire [`NUM_ERR_SRC-1:0]         err_event;
  reg  [`TRIG_W-1:0]              nxt_cs_crc_irq_trigger;
  reg  [`TRIG_W-1:0]              nxt_parity_irq_trigger;
  reg  [`TRIG_W-1:0]              nxt_validity_irq_trigger;
  reg  [`TRIG_W-1:0]              nxt_biphase_irq_trigger;
  reg  [`TRIG_W-1:0]              nxt_slip_irq_trigger;
  reg  [`SEL_W-1:0]               nxt_gp_out_one_source;
  reg  [`DATA_W-1:0]              nxt_reg_rdata;
  reg                             nxt_rd_valid;
  wire                            cs_crc_wr_ok;
  wire                            parity_wr_ok;
  wire                            validity_wr_ok;
  wire                            biphase_wr_ok;
  wire                            slip_wr_ok;
  wire                            source_wr_ok;

  assign wr_mode_b   = i_reg_wr_en && (i_reg_addr == `OFS_TRIG_MODE_B);
  assign wr_mode_c   = i_reg_wr_en && (i_reg_addr == `OFS_TRIG_MODE_C);
  assign wr_pin_one  = i_reg_wr_en && (i_reg_addr == `OFS_PIN_ONE_SEL);
  assign wr_cs_crc   = i_reg_wdata[`CS_CRC_TRIG_MSB:`CS_CRC_TRIG_LSB];
  assign wr_parity   = i_reg_wdata[`PARITY_TRIG_MSB:`PARITY_TRIG_LSB];
  assign wr_validity = i_reg_wdata[`VALIDITY_TRIG_MSB:`VALIDITY_TRIG_LSB];
  assign wr_biphase  = i_reg_wdata[`BIPHASE_TRIG_MSB:`BIPHASE_TRIG_LSB];
  assign wr_slip     = i_reg_wdata[`SLIP_TRIG_MSB:`SLIP_TRIG_LSB];
  assign wr_source   = i_reg_wdata[`SEL_MSB:`SEL_LSB];

  // per-field filter: a reserved code never reaches its flop
  assign cs_crc_wr_ok   = wr_mode_b && (wr_cs_crc != `TRIG_RSVD);
  assign parity_wr_ok   = wr_mode_b && (wr_parity != `TRIG_RSVD);
  assign validity_wr_ok = wr_mode_b && (wr_validity != `TRIG_RSVD);
  assign biphase_wr_ok  = wr_mode_b && (wr_biphase != `TRIG_RSVD);
  assign slip_wr_ok     = wr_mode_c && (wr_slip != `TRIG_RSVD);
  assign source_wr_ok   = wr_pin_one && (wr_source != `SEL_RSVD);

  // a reserved code in one field is dropped; the other fields of the same write still land
  always @* begin
    nxt_cs_crc_irq_trigger   = cs_crc_irq_trigger_ff;
    nxt_parity_irq_trigger   = parity_irq_trigger_ff;
    nxt_validity_irq_trigger = validity_irq_trigger_ff;
    nxt_biphase_irq_trigger  = biphase_irq_trigger_ff;
    nxt_slip_irq_trigger     = slip_irq_trigger_ff;
    nxt_gp_out_one_source    = gp_out_one_source_ff;
    if (cs_crc_wr_ok) begin
      nxt_cs_crc_irq_trigger = wr_cs_crc;
    end
    if (parity_wr_ok) begin
      nxt_parity_irq_trigger = wr_parity;
    end
    if (validity_wr_ok) begin
      nxt_validity_irq_trigger = wr_validity;
    end
    if (biphase_wr_ok) begin
      nxt_biphase_irq_trigger = wr_biphase;
    end
    if (slip_wr_ok) begin
      nxt_slip_irq_trigger = wr_slip;
    end
    if (source_wr_ok) begin
      nxt_gp_out_one_source = wr_source;
    end
  end

  always @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cs_crc_irq_trigger_ff   <= `TRIG_RESET;
      parity_irq_trigger_ff   <= `TRIG_RESET;
      validity_irq_trigger_ff <= `TRIG_RESET;
      biphase_irq_trigger_ff  <= `TRIG_RESET;
      slip_irq_trigger_ff     <= `TRIG_RESET;
      gp_out_one_source_ff    <= `SEL_RESET;
    end else begin
      cs_crc_irq_trigger_ff   <= nxt_cs_crc_irq_trigger;
      parity_irq_trigger_ff   <= nxt_parity_irq_trigger;
      validity_irq_trigger_ff <= nxt_validity_irq_trigger;
      biphase_irq_trigger_ff  <= nxt_biphase_irq_trigger;
      slip_irq_trigger_ff     <= nxt_slip_irq_trigger;
      gp_out_one_source_ff    <= nxt_gp_out_one_source;
    end
  end

  // read data: unused upper bits and unmapped offsets read zero
  always @* begin
    nxt_rdata = {`DATA_W{1'b0}};
    case (i_reg_addr)
      `OFS_TRIG_MODE_B: begin
        nxt_rdata[`CS_CRC_TRIG_MSB:`CS_CRC_TRIG_LSB]     = cs_crc_irq_trigger_ff;
        nxt_rdata[`PARITY_TRIG_MSB:`PARITY_TRIG_LSB]     = parity_irq_trigger_ff;
        nxt_rdata[`VALIDITY_TRIG_MSB:`VALIDITY_TRIG_LSB] = validity_irq_trigger_ff;
        nxt_rdata[`BIPHASE_TRIG_MSB:`BIPHASE_TRIG_LSB]   = biphase_irq_trigger_ff;
      end
      `OFS_TRIG_MODE_C: begin
        nxt_rdata[`SLIP_TRIG_MSB:`SLIP_TRIG_LSB] = slip_irq_trigger_ff;
      end
      `OFS_PIN_ONE_SEL: begin
        nxt_rdata[`SEL_MSB:`SEL_LSB] = gp_out_one_source_ff;
      end
      default: begin
        nxt_rdata = {`DATA_W{1'b0}};
      end
    endcase
  end

  // read data holds the last answer until the next read strobe
  always @* begin
    nxt_rd_valid  = i_reg_rd_en;
    nxt_reg_rdata = o_reg_rdata;
    if (i_reg_rd_en) begin
      nxt_reg_rdata = nxt_rdata;
    end
  end

  always @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_reg_rdata    <= {`DATA_W{1'b0}};
      o_reg_rd_valid <= 1'b0;
    end else begin
      o_reg_rdata    <= nxt_reg_rdata;
      o_reg_rd_valid <= nxt_rd_valid;
    end
  end

  assign err_cond[`ERR_CS_CRC]   = i_cs_crc_err;
  assign err_cond[`ERR_PARITY]   = i_parity_err;
  assign err_cond[`ERR_VALIDITY] = i_validity_err;
  assign err_cond[`ERR_BIPHASE]  = i_biphase_err;
  assign err_cond[`ERR_SLIP]     = i_slip_err;
  assign err_mode = {slip_irq_trigger_ff, biphase_irq_trigger_ff, validity_irq_trigger_ff,
                     parity_irq_trigger_ff, cs_crc_irq_trigger_ff};

  // the stored modes steer edge or level detection on each error source
  genvar src;
  generate
    for (src = 0; src < `NUM_ERR_SRC; src = src + 1) begin : g_err
      irq_trigger_detect u_detect (
        .i_core_clk (i_core_clk),
        .i_arst_n   (i_arst_n),
        .i_cond     (err_cond[src]),
        .i_mode     (err_mode[src*`TRIG_W +: `TRIG_W]),
        .o_event    (err_event[src])
      );
    end
  endgenerate

  // each event is the output flop of its detector
  assign o_cs_crc_irq_event   = err_event[`ERR_CS_CRC];
  assign o_parity_irq_event   = err_event[`ERR_PARITY];
  assign o_validity_irq_event = err_event[`ERR_VALIDITY];
  assign o_biphase_irq_event  = err_event[`ERR_BIPHASE];
  assign o_slip_irq_event     = err_event[`ERR_SLIP];

  gpo_source_mux u_pin_one_mux (
    .i_core_clk      (i_core_clk),
    .i_arst_n        (i_arst_n),
    .i_sel           (gp_out_one_source_ff),
    .i_tx_irq        (i_tx_irq),
    .i_rx_irq        (i_rx_irq),
    .i_rx_emphasis   (i_rx_emphasis),
    .i_rx_non_audio  (i_rx_non_audio),
    .i_rx_non_valid  (i_rx_non_valid),
    .i_rx_cs_bit     (i_rx_cs_bit),
    .i_rx_user_bit   (i_rx_user_bit),
    .i_rx_block_clk  (i_rx_block_clk),
    .i_rx_copy_bit   (i_rx_copy_bit),
    .i_rx_gen_bit    (i_rx_gen_bit),
    .i_rx_parity_err (i_parity_err),
    .i_rx_sync_clk   (i_rx_sync_clk),
    .i_tx_sync_clk   (i_tx_sync_clk),
    .o_pin           (o_gp_out_pin_one)
  );

endmodule
